// [hw/flow_reply_map.vh]
`ifndef FLOW_REPLY_MAP_VH
`define FLOW_REPLY_MAP_VH

// Register offsets (byte addresses)
`define OFS_CTRL 8'h00
`define OFS_MODE 8'h04
`define OFS_ID 8'h08
`define OFS_DLEN 8'h0c
`define OFS_DLO 8'h10
`define OFS_DHI 8'h14
`define OFS_STAT 8'h18
`define OFS_COUNT 8'h1c

// Control fields and reset value
`define CTRL_EN_BIT 0
`define CTRL_FMT_BIT 1
`define CTRL_RST 2'h3

// Reply modes
`define MODE_AUTO 2'h0
`define MODE_CUSTOM 2'h1
`define MODE_COPY_ID 2'h2
`define MODE_RST 2'h0

// Custom identifier fields
`define ID_EXT_BIT 31
`define ID_STD_MSB 10
`define ID_EXT_MSB 28

// Status fields
`define STAT_ERR_BIT 0
`define STAT_OVR_BIT 1
`define STAT_IDDEF_BIT 2
`define STAT_DDEF_BIT 3
`define STAT_PEND_BIT 4

// Frame content
`define MAX_BYTES 4'h8
`define FC_PCI_CTS 8'h30
`define AUTO_BLOCK 8'h00
`define AUTO_STMIN 8'h00
`define FILL_BYTE 8'h00
`define STD_RESP_OFS 11'h008

`endif

// [hw/sticky_flag.v]
`timescale 1ns/1ps
`include "flow_reply_map.vh"

module sticky_flag (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// Event and clear
	input wire set,
	input wire clr,
	// State
	output reg flag_reg
);

	wire flag_next;

	// Set beats clear so no event is lost
	assign flag_next = set | (flag_reg & ~clr);

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flag_reg <= 1'b0;
		end else begin
			flag_reg <= flag_next;
		end
	end

endmodule // sticky_flag

// [hw/flow_reply_gen.v]
`timescale 1ns/1ps
`include "flow_reply_map.vh"

module flow_reply_gen (
	// Selection
	input wire [1:0] mode,
	// Received first frame
	input wire [28:0] ff_id,
	input wire ff_ext,
	// Stored custom content
	input wire [28:0] cust_id,
	input wire cust_ext,
	input wire [3:0] cust_len,
	input wire [63:0] cust_data,
	// Built reply
	output reg [28:0] gen_id,
	output reg gen_ext,
	output reg [3:0] gen_dlc,
	output reg [63:0] gen_data
);

	reg [28:0] auto_id;

	always @* begin
		auto_id = 29'h0;
		// Standard answer: physical request id pairs with response id
		if (ff_ext) begin
			auto_id = {ff_id[28:16], ff_id[7:0], ff_id[15:8]};
		end else begin
			auto_id = {18'h0, ff_id[10:0] - `STD_RESP_OFS};
		end
		case (mode)
			`MODE_AUTO: begin
				gen_id = auto_id;
				gen_ext = ff_ext;
				gen_dlc = `MAX_BYTES;
				gen_data = {{5{`FILL_BYTE}}, `AUTO_STMIN, `AUTO_BLOCK,
					`FC_PCI_CTS};
			end
			`MODE_CUSTOM: begin
				gen_id = cust_id;
				gen_ext = cust_ext;
				gen_dlc = cust_len;
				gen_data = cust_data;
			end
			`MODE_COPY_ID: begin
				gen_id = ff_id;
				gen_ext = ff_ext;
				gen_dlc = cust_len;
				gen_data = cust_data;
			end
			default: begin
				gen_id = auto_id;
				gen_ext = ff_ext;
				gen_dlc = `MAX_BYTES;
				gen_data = {{5{`FILL_BYTE}}, `AUTO_STMIN, `AUTO_BLOCK,
					`FC_PCI_CTS};
			end
		endcase
	end

endmodule // flow_reply_gen

// [hw/can_flow_control_responder.v]
`timescale 1ns/1ps
`include "flow_reply_map.vh"

// Summary of operation
// - Frames carry at most eight data bytes
// - Sender waits for our flow reply
// - Auto reply only when enable set; default on
// - Mode defaults zero; device supplies everything
// - Mode one sends stored id and data
// - Mode one refused unless id, data defined
// - Custom id standard or extended, kept
// - Mode two copies received id, user data
// - Mode zero restores automatic content immediately
// - No reply unless segmented transport format
module can_flow_control_responder (
	// Clock and reset
	input wire pclk,
	input wire presetn,
	// APB slave
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	// Received first frame
	input wire ff_valid,
	input wire [28:0] ff_id,
	input wire ff_ext,
	// Flow control reply out
	output reg reply_valid,
	input wire reply_ready,
	output reg [28:0] reply_id,
	output reg reply_ext,
	output reg [3:0] reply_dlc,
	output reg [63:0] reply_data
);

	// Register state
	reg [1:0] ctrl_reg;
	reg [1:0] mode_reg;
	// Custom reply content
	reg [28:0] cust_id_reg;
	reg cust_ext_reg;
	reg id_def_reg;
	reg [3:0] dlen_reg;
	reg data_def_reg;
	reg [63:0] data_reg;
	// Replies handed over
	reg [15:0] count_reg;

	// Decode
	wire acc;
	wire wr_acc;
	wire rd_setup;
	wire sel_ctrl;
	wire sel_mode;
	wire sel_id;
	wire sel_dlen;
	wire sel_dlo;
	wire sel_dhi;
	wire sel_stat;
	wire sel_count;
	wire mapped;
	wire wr_mode;
	wire wr_dlen;
	wire [1:0] req_mode;
	reg mode_ok;
	wire dlen_ok;
	wire [3:0] req_len;

	// Reply path
	wire fc_en;
	wire fmt_ok;
	wire ff_live;
	wire slot_free;
	wire take_ff;
	wire ovr_set;
	wire sent;
	wire err_flag;
	wire ovr_flag;
	wire err_set;
	wire err_clr;
	wire ovr_clr;
	wire [28:0] gen_id;
	wire gen_ext;
	wire [3:0] gen_dlc;
	wire [63:0] gen_data;
	reg [31:0] rd_mux;

	// APB phase decode
	assign acc = psel & penable;
	assign wr_acc = acc & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;

	// Exact match, so no offset aliases
	assign sel_ctrl = (paddr == `OFS_CTRL);
	assign sel_mode = (paddr == `OFS_MODE);
	assign sel_id = (paddr == `OFS_ID);
	assign sel_dlen = (paddr == `OFS_DLEN);
	assign sel_dlo = (paddr == `OFS_DLO);
	assign sel_dhi = (paddr == `OFS_DHI);
	assign sel_stat = (paddr == `OFS_STAT);
	assign sel_count = (paddr == `OFS_COUNT);
	assign mapped = sel_ctrl | sel_mode | sel_id | sel_dlen | sel_dlo |
		sel_dhi | sel_stat | sel_count;

	// Write strobes and request fields
	assign wr_mode = wr_acc & sel_mode;
	assign wr_dlen = wr_acc & sel_dlen;
	assign req_mode = pwdata[1:0];
	assign req_len = pwdata[3:0];

	// Mode request check
	always @* begin
		case (req_mode)
			`MODE_AUTO: begin
				mode_ok = 1'b1;
			end
			`MODE_CUSTOM: begin
				mode_ok = id_def_reg & data_def_reg;
			end
			`MODE_COPY_ID: begin
				mode_ok = data_def_reg;
			end
			// Mode three is reserved
			default: begin
				mode_ok = 1'b0;
			end
		endcase
	end

	assign dlen_ok = (req_len != 4'h0) & (req_len <= `MAX_BYTES);

	// Zero wait states keep the master simple
	assign pready = 1'b1;
	assign pslverr = acc & (~mapped | (wr_mode & ~mode_ok) |
		(wr_dlen & ~dlen_ok));

	// Control register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `CTRL_RST;
		end else if (wr_acc & sel_ctrl) begin
			// Clearing bit one silences every reply
			ctrl_reg <= pwdata[1:0];
		end
	end

	// Mode register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= `MODE_RST;
		end else if (wr_mode & mode_ok) begin
			mode_reg <= req_mode;
		end
	end

	// Custom identifier
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cust_id_reg <= 29'h0;
			cust_ext_reg <= 1'b0;
			id_def_reg <= 1'b0;
		end else if (wr_acc & sel_id) begin
			cust_ext_reg <= pwdata[`ID_EXT_BIT];
			if (pwdata[`ID_EXT_BIT]) begin
				cust_id_reg <= pwdata[`ID_EXT_MSB:0];
			end else begin
				// Upper bits cleared so readback is clean
				cust_id_reg <= {18'h0, pwdata[`ID_STD_MSB:0]};
			end
			id_def_reg <= 1'b1;
		end
	end

	// Custom data length; its write defines the data
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dlen_reg <= 4'h0;
			data_def_reg <= 1'b0;
		end else if (wr_dlen & dlen_ok) begin
			dlen_reg <= req_len;
			data_def_reg <= 1'b1;
		end
	end

	// Custom data bytes, byte 0 in the low bits
	// Bytes past the length ride along unused
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			data_reg <= 64'h0;
		end else if (wr_acc & sel_dlo) begin
			data_reg[31:0] <= pwdata;
		end else if (wr_acc & sel_dhi) begin
			data_reg[63:32] <= pwdata;
		end
	end

	// Reply gating
	// Both bits must be set for any answer
	assign fc_en = ctrl_reg[`CTRL_EN_BIT];
	assign fmt_ok = ctrl_reg[`CTRL_FMT_BIT];
	assign ff_live = ff_valid & fc_en & fmt_ok;

	// Handshake with the far side
	assign sent = reply_valid & reply_ready;
	// Ready frees the slot at the same edge
	assign slot_free = ~reply_valid | reply_ready;
	assign take_ff = ff_live & slot_free;
	// A first frame while a reply still waits is lost
	assign ovr_set = ff_live & ~slot_free;

	flow_reply_gen u_gen (
		.mode(mode_reg),
		.ff_id(ff_id),
		.ff_ext(ff_ext),
		.cust_id(cust_id_reg),
		.cust_ext(cust_ext_reg),
		.cust_len(dlen_reg),
		.cust_data(data_reg),
		.gen_id(gen_id),
		.gen_ext(gen_ext),
		.gen_dlc(gen_dlc),
		.gen_data(gen_data)
	);

	// Reply holding register
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reply_valid <= 1'b0;
			reply_id <= 29'h0;
			reply_ext <= 1'b0;
			reply_dlc <= 4'h0;
			reply_data <= 64'h0;
		end else if (take_ff) begin
			// content from mode at this frame
			reply_valid <= 1'b1;
			reply_id <= gen_id;
			reply_ext <= gen_ext;
			reply_dlc <= gen_dlc;
			reply_data <= gen_data;
		end else if (sent) begin
			reply_valid <= 1'b0;
		end
	end

	// Sent replies counter; write clears, increment wins
	// Wraps at the top; software takes differences
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_reg <= 16'h0;
		end else if (sent) begin
			count_reg <= count_reg + 16'h1;
		end else if (wr_acc & sel_count) begin
			count_reg <= 16'h0;
		end
	end

	// Sticky flags, cleared by writing one
	assign err_set = wr_mode & ~mode_ok;
	assign err_clr = wr_acc & sel_stat & pwdata[`STAT_ERR_BIT];
	assign ovr_clr = wr_acc & sel_stat & pwdata[`STAT_OVR_BIT];

	sticky_flag u_err (
		.pclk(pclk),
		.presetn(presetn),
		.set(err_set),
		.clr(err_clr),
		.flag_reg(err_flag)
	);

	// Overrun: frame dropped while slot busy
	sticky_flag u_ovr (
		.pclk(pclk),
		.presetn(presetn),
		.set(ovr_set),
		.clr(ovr_clr),
		.flag_reg(ovr_flag)
	);

	// Read mux
	always @* begin
		rd_mux = 32'h0;
		case (paddr)
			`OFS_CTRL: begin
				rd_mux = {30'h0, ctrl_reg};
			end
			`OFS_MODE: begin
				rd_mux = {30'h0, mode_reg};
			end
			`OFS_ID: begin
				rd_mux = {cust_ext_reg, 2'h0, cust_id_reg};
			end
			`OFS_DLEN: begin
				rd_mux = {28'h0, dlen_reg};
			end
			`OFS_DLO: begin
				rd_mux = data_reg[31:0];
			end
			`OFS_DHI: begin
				rd_mux = data_reg[63:32];
			end
			// Pending, defined flags, then sticky flags
			`OFS_STAT: begin
				rd_mux = {27'h0, reply_valid, data_def_reg, id_def_reg,
					ovr_flag, err_flag};
			end
			`OFS_COUNT: begin
				rd_mux = {16'h0, count_reg};
			end
			// Unmapped offsets read as zero
			default: begin
				rd_mux = 32'h0;
			end
		endcase
	end

	// Read data captured in setup, stable through access
	// A change in the access cycle shows on the next read
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			prdata <= rd_mux;
		end
	end

endmodule // can_flow_control_responder

// [bench/responder_properties.sv]
`timescale 1ns/1ps
module responder_props (
	// Clock and bus
	input wire pclk, presetn, psel, penable, pwrite, pslverr,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	// Frames
	input wire ff_valid, ff_ext, reply_valid, reply_ready, reply_ext,
	input wire [28:0] ff_id, reply_id,
	input wire [3:0] reply_dlc,
	input wire [63:0] reply_data
);
	reg [1:0] mode_reg;
	wire mw = psel && penable && pwrite && paddr == 8'h04;
	wire take = ff_valid && !reply_valid;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Mode as the block accepted it
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_reg <= 2'h0;
		else if (mw && !pslverr)
			mode_reg <= pwdata[1:0];
	end
	reply_cause_a: assert property (
		$rose(reply_valid) |-> $past(ff_valid)) else $error("stray reply");
	reply_next_a: assert property (
		reply_valid && reply_ready && !ff_valid |=> !reply_valid)
		else $error("reply repeated");
	reply_hold_a: assert property (
		reply_valid && !reply_ready |=> reply_valid && $stable(reply_id)
		&& $stable(reply_data)) else $error("reply moved");
	reply_keep_a: assert property (
		$fell(reply_valid) && $past(presetn) |-> $past(reply_ready))
		else $error("reply lost");
	dlc_max_a: assert property (
		reply_valid |-> reply_dlc <= 4'h8) else $error("long reply");
	auto_back_a: assert property (
		mw && pwdata[1:0] == 2'h0 |-> !pslverr) else $error("mode 0 refused");
	auto_reply_a: assert property (
		take && mode_reg == 2'h0 && !ff_ext |=> !reply_valid
		|| reply_dlc == 4'h8 && reply_data[15:0] == 16'h0030
		&& reply_id == $past(ff_id) - 29'h8) else $error("auto reply");
	copy_id_a: assert property (
		take && mode_reg == 2'h2 |=> !reply_valid || reply_id == $past(ff_id)
		&& reply_ext == $past(ff_ext)) else $error("copied id");
endmodule // responder_props

bind can_flow_control_responder responder_props u_props (.*);

// [bench/car_unit.sv]
`timescale 1ns/1ps
module car_unit (
	// Clock
	input wire pclk,
	// Reply sink
	input wire reply_valid,
	output reg reply_ready = 1'b0,
	// First frame source
	output reg ff_valid = 1'b0,
	output reg [28:0] ff_id = 29'h0,
	output reg ff_ext = 1'b0
);
	integer slow = 0;
	integer waited = 0;
	always @(posedge pclk) begin
		waited <= reply_valid && !reply_ready ? waited + 1 : 0;
		reply_ready <= reply_valid && !reply_ready && waited >= slow;
	end
	// Idle lines flip so a stale id is never read
	task ff(input [28:0] id, input ext);
		begin
			ff_valid <= 1'b1;
			ff_id <= id;
			ff_ext <= ext;
			@(posedge pclk);
			ff_valid <= 1'b0;
			ff_id <= ~id;
			ff_ext <= ~ext;
			@(posedge pclk);
		end
	endtask
endmodule // car_unit

// [bench/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
	reg pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	reg pwrite = 1'b0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	wire [31:0] prdata;
	wire pready, pslverr, ff_valid, ff_ext, reply_valid, reply_ready;
	wire reply_ext;
	wire [28:0] ff_id, reply_id;
	wire [3:0] reply_dlc;
	wire [63:0] reply_data;
	localparam [63:0] cust = 64'h44332211_00ff3004;
	integer fail_count = 0, checks_done = 0, cyc = 0;
	always #10 pclk = ~pclk;
	can_flow_control_responder u_can_flow_control_responder (.*);
	car_unit u_car_unit (.*);
	// Hang guard, far above the run length
	always @(posedge pclk) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			fail_count = fail_count + 1;
			finish_test;
		end
	end
	task chk(input [127:0] got, input [127:0] exp);
		begin
			checks_done = checks_done + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task finish_test;
		begin
			$display("checks %0d fails %0d", checks_done, fail_count);
			if (fail_count == 0 && checks_done > 0)
				$display("ALL CHECKS OK");
			else
				$display("CHECKS NOT OK");
			$finish;
		end
	endtask
	// Write checks the error flag, read checks the data
	task io(input w, input [7:0] a, input [31:0] d, input [31:0] e);
		begin
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			do @(posedge pclk); while (pready !== 1'b1);
			chk(w ? pslverr : prdata, e);
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task rep(input [28:0] i, input x, input [3:0] l, input [63:0] d);
		begin
			do @(negedge pclk); while (reply_valid !== 1'b1);
			chk({reply_id, reply_ext, reply_dlc, reply_data}, {i, x, l, d});
			while (reply_valid === 1'b1) @(posedge pclk);
		end
	endtask
	task no_reply(input [31:0] c);
		begin
			io(1'b1, 8'h00, c, 32'h0);
			u_car_unit.ff(29'h7e8, 1'b0);
			@(negedge pclk);
			chk(reply_valid, 1'b0);
			@(posedge pclk);
		end
	endtask
	task t_regs;
		begin
			io(1'b0, 8'h00, 32'h0, 32'h3);
			io(1'b1, 8'h04, 32'h1, 32'h1);
			io(1'b1, 8'h04, 32'h2, 32'h1);
			io(1'b1, 8'h04, 32'h3, 32'h1);
			io(1'b0, 8'h04, 32'h0, 32'h0);
			io(1'b1, 8'h0c, 32'h9, 32'h1);
			io(1'b1, 8'h0c, 32'h0, 32'h1);
			io(1'b1, 8'h08, 32'h1fff, 32'h0);
			io(1'b0, 8'h08, 32'h0, 32'h7ff);
			$display("regs end");
		end
	endtask
	task t_auto;
		begin
			u_car_unit.ff(29'h7e8, 1'b0);
			rep(29'h7e0, 1'b0, 4'h8, 64'h30);
			u_car_unit.ff(29'h18da10f1, 1'b1);
			rep(29'h18daf110, 1'b1, 4'h8, 64'h30);
			no_reply(32'h2);
			no_reply(32'h1);
			io(1'b1, 8'h00, 32'h3, 32'h0);
			$display("auto end");
		end
	endtask
	task t_custom;
		begin
			io(1'b1, 8'h10, cust[31:0], 32'h0);
			io(1'b1, 8'h14, cust[63:32], 32'h0);
			io(1'b1, 8'h0c, 32'h4, 32'h0);
			io(1'b1, 8'h04, 32'h1, 32'h0);
			u_car_unit.ff(29'h7c0, 1'b0);
			rep(29'h7ff, 1'b0, 4'h4, cust);
			io(1'b1, 8'h08, 32'h9abcdef0, 32'h0);
			u_car_unit.ff(29'h7c0, 1'b0);
			rep(29'h1abcdef0, 1'b1, 4'h4, cust);
			$display("custom end");
		end
	endtask
	task t_copy;
		begin
			io(1'b1, 8'h04, 32'h2, 32'h0);
			u_car_unit.slow = 6;
			u_car_unit.ff(29'h18daf110, 1'b1);
			u_car_unit.ff(29'h7e8, 1'b0);
			rep(29'h18daf110, 1'b1, 4'h4, cust);
			io(1'b0, 8'h18, 32'h0, 32'hf);
			io(1'b1, 8'h18, 32'h3, 32'h0);
			io(1'b0, 8'h18, 32'h0, 32'hc);
			io(1'b1, 8'h04, 32'h0, 32'h0);
			u_car_unit.ff(29'h7e8, 1'b0);
			rep(29'h7e0, 1'b0, 4'h8, 64'h30);
			io(1'b0, 8'h1c, 32'h0, 32'h6);
			io(1'b1, 8'h1c, 32'h0, 32'h0);
			io(1'b0, 8'h1c, 32'h0, 32'h0);
			$display("copy end");
		end
	endtask
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_auto;
		t_custom;
		t_copy;
		finish_test;
	end
endmodule // tb_top
